// *** core/phy_basic_mgmt_registers.sv ***
// basic control, basic status and upper identifier registers of one
// phy port, reached over the serial management pins mdc/mdio.
// assumes mdc is slow against mclk (at least 8 mclk per mdc phase)
// and that core status inputs are already on mclk.
`timescale 1ns/1ns

// Functional notes
// - writing one to control bit 9 pulses negotiation restart, reads zero
// - control bit 8 forces half or full duplex when negotiation off
// - control bit 7 raises collision whenever the port transmits
// - rate bit resets to negotiation strap OR rate strap
// - negotiation enable resets to the negotiation strap
// - duplex bit resets to duplex strap AND NOT negotiation strap
// - capability bits read only: 15,10,9 zero, 14 to 11 one
// - status bit 5 shows negotiation complete, follows the input live
// - status bit 4 is latched-high remote fault, resets zero
// - status bit 3 always reads one
// - status bit 2 is latched-low link state, resets zero
// - status bit 1 is latched-high jabber, resets zero
// - status bit 0 always reads one
// - status register at index 1, 16 bits, bits 8 to 6 read zero
// - upper identifier is writable 16 bits, resets to fixed pattern
// - upper identifier register sits at index 2
// - with negotiation on, rate and duplex come from negotiation
module phy_basic_mgmt_registers #(
    parameter logic [4:0] PHY_ADDR = phy_mgmt_pkg::PHY_ADDR_DEFAULT,
    parameter logic [15:0] IDENT_UPPER = phy_mgmt_pkg::IDENT_UPPER_RESET
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    input wire logic neg_strap,
    input wire logic rate_strap,
    input wire logic duplex_strap,
    input wire logic link_up,
    input wire logic neg_complete,
    input wire logic remote_fault,
    input wire logic jabber,
    input wire logic tx_active,
    input wire logic neg_rate_100,
    input wire logic neg_full_duplex,
    output logic negotiation_restart,
    output logic negotiation_enable,
    output logic rate_100,
    output logic full_duplex,
    output logic collision
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    pin_sync_if #(.WIDTH(phy_mgmt_pkg::SYNC_W)) pins ();
    assign pins.raw[phy_mgmt_pkg::LANE_MDC] = mdc;
    assign pins.raw[phy_mgmt_pkg::LANE_MDIO] = mdio_in;
    assign pins.raw[phy_mgmt_pkg::LANE_NEG_STRAP] = neg_strap;
    assign pins.raw[phy_mgmt_pkg::LANE_RATE_STRAP] = rate_strap;
    assign pins.raw[phy_mgmt_pkg::LANE_DUPLEX_STRAP] = duplex_strap;
    pin_sync #(.WIDTH(phy_mgmt_pkg::SYNC_W)) u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .pins(pins)
    );
    logic mdc_s;
    logic mdio_s;
    assign mdc_s = pins.clean[phy_mgmt_pkg::LANE_MDC];
    assign mdio_s = pins.clean[phy_mgmt_pkg::LANE_MDIO];

    // ------------------------------------------------------------------
    // mdc rising edge
    // ------------------------------------------------------------------
    logic mdc_prev;
    logic mdc_rise;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mdc_prev <= 1'b0;
        end else begin
            mdc_prev <= mdc_s;
        end
    end
    assign mdc_rise = mdc_s & ~mdc_prev;

    // ------------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------------
    // straps must first travel through the synchroniser, so they are
    // taken a few cycles after release rather than at the reset edge
    logic [2:0] settle_cnt;
    logic strap_load;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            settle_cnt <= 3'h0;
            strap_load <= 1'b0;
        end else begin
            strap_load <= 1'b0;
            if (settle_cnt != phy_mgmt_pkg::STRAP_SETTLE) begin
                settle_cnt <= settle_cnt + 3'h1;
                if (settle_cnt == phy_mgmt_pkg::STRAP_SETTLE - 3'h1) begin
                    strap_load <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // management frame engine
    // ------------------------------------------------------------------
    phy_mgmt_pkg::frame_state_t state;
    logic [5:0] pre_cnt;
    logic [4:0] bit_cnt;
    logic [12:0] hdr;
    logic [12:0] next_hdr;
    logic [4:0] reg_idx;
    logic [15:0] shift;
    logic [15:0] read_value;
    logic wr_stb;
    logic [4:0] wr_idx;
    logic [15:0] wr_data;
    logic status_read;
    logic hdr_ok;
    assign next_hdr = {hdr[11:0], mdio_s};
    // next_hdr: [12] second start bit, [11:10] op, [9:5] addr, [4:0] reg
    assign hdr_ok = next_hdr[12] & (next_hdr[9:5] == PHY_ADDR) &
        ((next_hdr[11:10] == phy_mgmt_pkg::OP_READ) |
         (next_hdr[11:10] == phy_mgmt_pkg::OP_WRITE));

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= phy_mgmt_pkg::S_PRE;
            pre_cnt <= 6'h00;
            bit_cnt <= 5'h00;
            hdr <= 13'h0000;
            reg_idx <= 5'h00;
            shift <= 16'h0000;
            mdio_out <= 1'b1;
            mdio_oe_n <= 1'b1;
            wr_stb <= 1'b0;
            wr_idx <= 5'h00;
            wr_data <= 16'h0000;
            status_read <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            status_read <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    phy_mgmt_pkg::S_PRE: begin
                        if (mdio_s) begin
                            if (pre_cnt != phy_mgmt_pkg::PREAMBLE_LEN) begin
                                pre_cnt <= pre_cnt + 6'h01;
                            end
                        end else begin
                            // a zero after a full preamble is the start
                            if (pre_cnt == phy_mgmt_pkg::PREAMBLE_LEN) begin
                                state <= phy_mgmt_pkg::S_HDR;
                                bit_cnt <= 5'h00;
                            end
                            pre_cnt <= 6'h00;
                        end
                    end
                    phy_mgmt_pkg::S_HDR: begin
                        hdr <= next_hdr;
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt[3:0] == phy_mgmt_pkg::HDR_LAST) begin
                            bit_cnt <= 5'h00;
                            reg_idx <= next_hdr[4:0];
                            if (hdr_ok) begin
                                state <= phy_mgmt_pkg::S_TA;
                            end else begin
                                state <= phy_mgmt_pkg::S_PRE;
                            end
                        end
                    end
                    phy_mgmt_pkg::S_TA: begin
                        if (hdr[11:10] == phy_mgmt_pkg::OP_READ) begin
                            // second turnaround bit is driven low
                            mdio_oe_n <= 1'b0;
                            mdio_out <= 1'b0;
                            shift <= read_value;
                            status_read <= (reg_idx ==
                                phy_mgmt_pkg::REG_STATUS);
                            state <= phy_mgmt_pkg::S_RD;
                            bit_cnt <= 5'h00;
                        end else if (bit_cnt != 5'h00) begin
                            state <= phy_mgmt_pkg::S_WR;
                            bit_cnt <= 5'h00;
                        end else begin
                            bit_cnt <= 5'h01;
                        end
                    end
                    phy_mgmt_pkg::S_RD: begin
                        if (bit_cnt == phy_mgmt_pkg::DATA_END) begin
                            mdio_oe_n <= 1'b1;
                            mdio_out <= 1'b1;
                            state <= phy_mgmt_pkg::S_PRE;
                        end else begin
                            mdio_out <= shift[15];
                            shift <= {shift[14:0], 1'b0};
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                    end
                    phy_mgmt_pkg::S_WR: begin
                        shift <= {shift[14:0], mdio_s};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == phy_mgmt_pkg::DATA_LAST) begin
                            wr_stb <= 1'b1;
                            wr_idx <= reg_idx;
                            wr_data <= {shift[14:0], mdio_s};
                            state <= phy_mgmt_pkg::S_PRE;
                        end
                    end
                    default: begin
                        state <= phy_mgmt_pkg::S_PRE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    logic ctrl_rate;
    logic ctrl_neg_en;
    logic ctrl_duplex;
    logic ctrl_col_test;
    logic wr_ctrl;
    assign wr_ctrl = wr_stb & (wr_idx == phy_mgmt_pkg::REG_CONTROL);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_rate <= 1'b0;
            ctrl_neg_en <= 1'b0;
            ctrl_duplex <= 1'b0;
            ctrl_col_test <= 1'b0;
        end else if (strap_load) begin
            ctrl_rate <= pins.clean[phy_mgmt_pkg::LANE_NEG_STRAP] |
                pins.clean[phy_mgmt_pkg::LANE_RATE_STRAP];
            ctrl_neg_en <=
                pins.clean[phy_mgmt_pkg::LANE_NEG_STRAP];
            ctrl_duplex <= pins.clean[phy_mgmt_pkg::LANE_DUPLEX_STRAP] &
                ~pins.clean[phy_mgmt_pkg::LANE_NEG_STRAP];
            ctrl_col_test <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_rate <= wr_data[phy_mgmt_pkg::CTRL_RATE];
            ctrl_neg_en <= wr_data[phy_mgmt_pkg::CTRL_NEG_EN];
            ctrl_duplex <= wr_data[phy_mgmt_pkg::CTRL_DUPLEX];
            ctrl_col_test <= wr_data[phy_mgmt_pkg::CTRL_COL_TEST];
        end
    end

    // restart is a one-cycle pulse and never stored, so it reads zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            negotiation_restart <= 1'b0;
        end else begin
            negotiation_restart <= wr_ctrl &
                wr_data[phy_mgmt_pkg::CTRL_RESTART];
        end
    end

    // ------------------------------------------------------------------
    // upper identifier register
    // ------------------------------------------------------------------
    logic [15:0] ident_upper;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ident_upper <= IDENT_UPPER;
        end else if (wr_stb &&
                (wr_idx == phy_mgmt_pkg::REG_IDENT_UPPER)) begin
            ident_upper <= wr_data;
        end
    end

    // ------------------------------------------------------------------
    // latched status flags
    // ------------------------------------------------------------------
    // an event in the read cycle itself survives: the new level is
    // or-ed (or and-ed for link) after the release by the read
    logic fault_latch;
    logic jabber_latch;
    logic link_latch;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fault_latch <= 1'b0;
            jabber_latch <= 1'b0;
            link_latch <= 1'b0;
        end else begin
            fault_latch <= remote_fault |
                (fault_latch & ~status_read);
            jabber_latch <= jabber |
                (jabber_latch & ~status_read);
            link_latch <= link_up &
                (link_latch | status_read);
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [15:0] status_value;
    logic [15:0] control_value;

    always_comb begin
        // bits 15,10,9 and 8:6 stay zero; 14:11, 3 and 0 are fixed ones
        status_value = phy_mgmt_pkg::STAT_FIXED;
        status_value[phy_mgmt_pkg::STAT_NEG_DONE] = neg_complete;
        status_value[phy_mgmt_pkg::STAT_REMOTE_FAULT] = fault_latch;
        status_value[phy_mgmt_pkg::STAT_LINK] = link_latch;
        status_value[phy_mgmt_pkg::STAT_JABBER] = jabber_latch;
    end

    always_comb begin
        control_value = 16'h0000;
        control_value[phy_mgmt_pkg::CTRL_RATE] = ctrl_rate;
        control_value[phy_mgmt_pkg::CTRL_NEG_EN] = ctrl_neg_en;
        control_value[phy_mgmt_pkg::CTRL_DUPLEX] = ctrl_duplex;
        control_value[phy_mgmt_pkg::CTRL_COL_TEST] = ctrl_col_test;
    end

    always_comb begin
        if (reg_idx == phy_mgmt_pkg::REG_CONTROL) begin
            read_value = control_value;
        end else if (reg_idx == phy_mgmt_pkg::REG_STATUS) begin
            read_value = status_value;
        end else if (reg_idx == phy_mgmt_pkg::REG_IDENT_UPPER) begin
            read_value = ident_upper;
        end else begin
            read_value = 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // controls toward the phy core
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            negotiation_enable <= 1'b0;
            rate_100 <= 1'b0;
            full_duplex <= 1'b0;
        end else begin
            negotiation_enable <= ctrl_neg_en;
            if (ctrl_neg_en) begin
                rate_100 <= neg_rate_100;
                full_duplex <= neg_full_duplex;
            end else begin
                rate_100 <= ctrl_rate;
                full_duplex <= ctrl_duplex;
            end
        end
    end

    // no loopback check here: the loopback advice is left to software
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            collision <= 1'b0;
        end else begin
            collision <= ctrl_col_test & tx_active;
        end
    end

endmodule

// *** core/phy_mgmt_pkg.sv ***
// constants for the port phy management register bank
// assumes a single mclk domain and a serial management host on mdc/mdio
package phy_mgmt_pkg;

    // ------------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_CONTROL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_IDENT_UPPER = 5'h02;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_RATE = 13;
    localparam int CTRL_NEG_EN = 12;
    localparam int CTRL_RESTART = 9;
    localparam int CTRL_DUPLEX = 8;
    localparam int CTRL_COL_TEST = 7;

    // ------------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------------
    localparam int STAT_NEG_DONE = 5;
    localparam int STAT_REMOTE_FAULT = 4;
    localparam int STAT_LINK = 2;
    localparam int STAT_JABBER = 1;
    // fixed part: 100tx fd/hd, 10t fd/hd, negotiation able, extended set
    localparam logic [15:0] STAT_FIXED = 16'h7809;

    // neutral identifier, value is arbitrary
    localparam logic [15:0] IDENT_UPPER_RESET = 16'h1234;

    // ------------------------------------------------------------------
    // management frame layout
    // ------------------------------------------------------------------
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [3:0] HDR_LAST = 4'hc;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    localparam logic [4:0] DATA_END = 5'h10;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h01;

    // cycles after reset release before straps are taken
    localparam logic [2:0] STRAP_SETTLE = 3'h5;

    // pin synchroniser lanes
    localparam int SYNC_W = 5;
    localparam int LANE_MDC = 0;
    localparam int LANE_MDIO = 1;
    localparam int LANE_NEG_STRAP = 2;
    localparam int LANE_RATE_STRAP = 3;
    localparam int LANE_DUPLEX_STRAP = 4;

    typedef enum logic [4:0] {
        S_PRE = 5'h01,
        S_HDR = 5'h02,
        S_TA = 5'h04,
        S_RD = 5'h08,
        S_WR = 5'h10
    } frame_state_t;

endpackage

// *** core/pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
// assumes raw inputs are asynchronous to mclk
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 5
) (
    input wire logic mclk,
    input wire logic arst_n,
    pin_sync_if.sync pins
);

    // ------------------------------------------------------------------
    // per-lane stages
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
            logic q1;
            logic q2;
            logic q3;
            logic level;
            // only q2 reads q1; a change is taken when q2 and q3 agree
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    q1 <= 1'b0;
                    q2 <= 1'b0;
                    q3 <= 1'b0;
                    level <= 1'b0;
                end else begin
                    q1 <= pins.raw[i];
                    q2 <= q1;
                    q3 <= q2;
                    if (q2 == q3) begin
                        level <= q3;
                    end
                end
            end
            assign pins.clean[i] = level;
        end
    endgenerate

endmodule

// *** core/pin_sync_if.sv ***
// bundle between the register bank and its pin synchroniser
// assumes both ends run on mclk
`timescale 1ns/1ns
interface pin_sync_if #(parameter int WIDTH = 5);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] clean;
    modport bank (output raw, input clean);
    modport sync (input raw, output clean);
endinterface

// *** dv/mdio_host.sv ***
// management host model driving mdc and the shared mdio line
// assumes mclk from the bench; mdc half period is 10 mclk
`timescale 1ns/1ns
module mdio_host (
    input wire logic mclk,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    output logic mdc,
    output logic mdio_in
);
    logic drv;
    logic dat;
    // released line floats to its pull-up level
    assign mdio_in = !mdio_oe_n ? mdio_out : (drv ? dat : 1'h1);
    initial begin
        mdc = 1'h0;
        drv = 1'h0;
        dat = 1'h1;
    end
    // mdc stands low between frames
    task automatic bit_cyc(input logic d, input logic en, output logic s);
        drv = en;
        dat = d;
        mdc = 1'h0;
        repeat (10) @(negedge mclk);
        s = mdio_in;
        mdc = 1'h1;
        repeat (10) @(negedge mclk);
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] idx,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic s;
        logic wr;
        hdr = {2'h1, op, phy_mgmt_pkg::PHY_ADDR_DEFAULT, idx};
        wr = (op == phy_mgmt_pkg::OP_WRITE);
        for (int i = 0; i < 32; i++) bit_cyc(1'h1, 1'h1, s);
        for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'h1, s);
        // a read hands the line over during turnaround
        for (int i = 1; i >= 0; i--) bit_cyc(i[0], wr, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cyc(wd[i], wr, s);
            rd[i] = s;
        end
        drv = 1'h0;
        mdc = 1'h0;
        repeat (40) @(negedge mclk);
    endtask
endmodule

// *** dv/phy_basic_mgmt_registers_checker.sv ***
// port-level assertions for the phy management register bank
// assumes one mclk domain; bound to the top module below
`timescale 1ns/1ns
module phy_basic_mgmt_registers_checker (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    input wire logic tx_active,
    input wire logic neg_rate_100,
    input wire logic neg_full_duplex,
    input wire logic negotiation_restart,
    input wire logic negotiation_enable,
    input wire logic rate_100,
    input wire logic full_duplex,
    input wire logic collision
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    AST_RESTART_PULSE: assert property (
        negotiation_restart |=> !negotiation_restart)
        else $error("restart longer than one cycle");
    AST_RESTART_IDLE: assert property (
        negotiation_restart |-> mdio_oe_n)
        else $error("restart during a read reply");
    AST_RATE_NEG: assert property (
        negotiation_enable && $past(negotiation_enable)
        |-> rate_100 == $past(neg_rate_100))
        else $error("rate not taken from negotiation");
    AST_DUPLEX_NEG: assert property (
        negotiation_enable && $past(negotiation_enable)
        |-> full_duplex == $past(neg_full_duplex))
        else $error("duplex not taken from negotiation");
    AST_COL_TX: assert property (
        collision |-> $past(tx_active))
        else $error("collision without transmit");
    AST_DUPLEX_HELD: assert property (
        !negotiation_enable && !$past(negotiation_enable) && !mdio_oe_n
        |-> $stable(full_duplex))
        else $error("forced duplex moved during a read");
    AST_TA_LOW: assert property (
        $fell(mdio_oe_n) |-> !mdio_out)
        else $error("reply does not start with zero");
    AST_READ_SPAN: assert property (
        $fell(mdio_oe_n) |-> ##250 !mdio_oe_n)
        else $error("reply word cut short");
endmodule
bind phy_basic_mgmt_registers phy_basic_mgmt_registers_checker chk_i (
    .mclk, .arst_n, .mdio_out, .mdio_oe_n, .tx_active, .neg_rate_100,
    .neg_full_duplex, .negotiation_restart, .negotiation_enable,
    .rate_100, .full_duplex, .collision);

// *** dv/tb_phy_basic_mgmt_registers.sv ***
// self-checking bench for the phy management register bank
// assumes the mdio_host model and the bound checker
`timescale 1ns/1ns
module tb_phy_basic_mgmt_registers;
    logic mclk = 1'h0;
    logic arst_n = 1'h0;
    logic mdc, mdio_in, mdio_out, mdio_oe_n;
    logic neg_strap = 1'h0, rate_strap = 1'h0, duplex_strap = 1'h0;
    logic link_up = 1'h0, neg_complete = 1'h0, remote_fault = 1'h0;
    logic jabber = 1'h0, tx_active = 1'h0;
    logic neg_rate_100 = 1'h0, neg_full_duplex = 1'h0;
    logic negotiation_restart, negotiation_enable, rate_100;
    logic full_duplex, collision;
    int error_cnt = 0;
    int checked = 0;
    int pulses = 0;
    logic ml, mf, mj;
    logic [15:0] rd, w, ctl;
    always #4 mclk = ~mclk;
    always @(posedge mclk) if (negotiation_restart) pulses++;
    phy_basic_mgmt_registers uut (.mclk, .arst_n, .mdc, .mdio_in,
        .mdio_out, .mdio_oe_n, .neg_strap, .rate_strap, .duplex_strap,
        .link_up, .neg_complete, .remote_fault, .jabber, .tx_active,
        .neg_rate_100, .neg_full_duplex, .negotiation_restart,
        .negotiation_enable, .rate_100, .full_duplex, .collision);
    mdio_host host (.mclk, .mdio_out, .mdio_oe_n, .mdc, .mdio_in);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic rdr(input logic [4:0] idx, output logic [15:0] d);
        host.frame(phy_mgmt_pkg::OP_READ, idx, 16'h0000, d);
    endtask
    task automatic wrr(input logic [4:0] idx, input logic [15:0] d);
        logic [15:0] x;
        host.frame(phy_mgmt_pkg::OP_WRITE, idx, d, x);
    endtask
    // latched flags report the held value, then reload the live one
    task automatic rd_stat();
        logic [15:0] e;
        e = 16'h7809 | {10'h000, neg_complete, mf, 1'h0, ml, mj, 1'h0};
        rdr(phy_mgmt_pkg::REG_STATUS, rd);
        chk(rd, e);
        mf = remote_fault;
        mj = jabber;
        ml = link_up;
    endtask
    task automatic chk_out();
        logic n;
        n = ctl[12];
        chk({13'h0000, negotiation_enable, rate_100, full_duplex},
            {13'h0000, n, n ? neg_rate_100 : ctl[13],
             n ? neg_full_duplex : ctl[8]});
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h31aa));
        for (int r = 0; r < 3; r++) begin
            arst_n = 1'h0;
            {neg_strap, rate_strap, duplex_strap} = 3'($urandom);
            repeat (20) @(negedge mclk);
            arst_n = 1'h1;
            {ml, mf, mj} = 3'h0;
            repeat (12) @(negedge mclk);
            ctl = {2'h0, neg_strap | rate_strap, neg_strap, 3'h0,
                   duplex_strap & ~neg_strap, 8'h00};
            rdr(phy_mgmt_pkg::REG_CONTROL, rd);
            chk(rd, ctl);
            chk_out();
            rdr(phy_mgmt_pkg::REG_IDENT_UPPER, rd);
            chk(rd, phy_mgmt_pkg::IDENT_UPPER_RESET);
            rd_stat();
        end
        link_up = 1'h1;
        neg_complete = 1'h1;
        rd_stat();
        rd_stat();
        // one-cycle fault, jabber and link drop between reads
        @(negedge mclk);
        {remote_fault, jabber, link_up} = 3'h6;
        @(negedge mclk);
        {remote_fault, jabber, link_up} = 3'h1;
        {mf, mj, ml} = 3'h6;
        rd_stat();
        rd_stat();
        wrr(phy_mgmt_pkg::REG_STATUS, 16'hffff);
        rd_stat();
        w = 16'($urandom);
        wrr(phy_mgmt_pkg::REG_IDENT_UPPER, w);
        wrr(5'h05, ~w);
        rdr(phy_mgmt_pkg::REG_IDENT_UPPER, rd);
        chk(rd, w);
        rdr(5'h05, rd);
        chk(rd, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            w = 16'($urandom) | 16'h0200;
            w[12] = i[0];
            // collision test is a self-check here; a real port loops back
            w[7] = i[1];
            {neg_rate_100, neg_full_duplex} = 2'($urandom);
            pulses = 0;
            wrr(phy_mgmt_pkg::REG_CONTROL, w);
            ctl = w & 16'h3180;
            chk(16'(pulses), 16'h0001);
            rdr(phy_mgmt_pkg::REG_CONTROL, rd);
            chk(rd, ctl);
            chk_out();
            tx_active = 1'h1;
            repeat (3) @(negedge mclk);
            chk({15'h0000, collision}, {15'h0000, ctl[7]});
            tx_active = 1'h0;
        end
        print_verdict();
    end
endmodule
